// ---- logic/msc_alu.sv ----
// Combinational shift and compare datapath of the accumulator unit.
// Assumes the caller registers results; no saturation input exists on purpose.
`default_nettype none
`timescale 1ns/1ns

module msc_alu (
   // Request
   input wire msc_pkg::msc_alu_in_type in_i,
   // Result
   output var msc_pkg::msc_alu_out_type out_o
);
   import msc_pkg::*;

   logic [ACC_WIDTH:0] ext_acc;
   logic [ACC_WIDTH:0] shifted;
   logic [ACC_WIDTH-1:0] diff;
   logic shout;

   always_comb begin
      out_o = '{acc: in_i.acc, status: in_i.status};
      ext_acc = {in_i.acc, 1'b0};
      shifted = ext_acc;
      diff = in_i.operand - in_i.acc;
      shout = 1'b0;
      case (in_i.cmd)
         // Saturation mode never reaches this path, so shifts cannot clamp
         CMD_LSHR, CMD_ASHR: begin
            // Whole 40 bits shift, so on a one-place shift extension bit 0 lands in high word bit 15
            if (in_i.cmd == CMD_ASHR) begin
               shifted = $signed(ext_acc) >>> in_i.amount;
            end else begin
               shifted = ext_acc >> in_i.amount;
            end
            shout = shifted[0];
            out_o.acc = shifted[ACC_WIDTH:1];
            out_o.status[ST_N_BIT] = shifted[ACC_WIDTH];
            out_o.status[ST_Z_BIT] = (shifted[ACC_WIDTH:1] == '0);
            out_o.status[ST_C_BIT] = shout;
            // Extension byte significant when it differs from sign of bit 31
            out_o.status[ST_E_BIT] = !((shifted[ACC_WIDTH:32] == '0)
               || (shifted[ACC_WIDTH:32] == '1));
         end
         CMD_CMP: begin
            // Operand minus accumulator; carry is the borrow
            out_o.status[ST_C_BIT] = (in_i.operand < in_i.acc);
            // Accumulator and zero flag untouched
            out_o.status[ST_N_BIT] = diff[ACC_WIDTH-1];
         end
         default: begin
            out_o = '{acc: in_i.acc, status: in_i.status};
         end
      endcase
   end

endmodule : msc_alu

`default_nettype wire

// ---- logic/msc_pkg.sv ----
// Constants and carrier types for the accumulator shift and compare unit.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`default_nettype none

package msc_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ACC_WIDTH = 40;
   localparam int WORD_WIDTH = 16;
   localparam int EXT_WIDTH = 8;
   localparam int AMT_WIDTH = 5;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ACC_LOW = 8'h08;
   localparam logic [7:0] OFF_ACC_HIGH = 8'h0c;
   localparam logic [7:0] OFF_ACC_EXT = 8'h10;
   localparam logic [7:0] OFF_OP_LOW = 8'h14;
   localparam logic [7:0] OFF_OP_HIGH = 8'h18;
   localparam logic [7:0] OFF_OP_EXT = 8'h1c;
   localparam logic [7:0] OFF_COMMAND = 8'h20;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTL_SAT_BIT = 7;
   localparam int ST_N_BIT = 8;
   localparam int ST_Z_BIT = 9;
   localparam int ST_C_BIT = 10;
   localparam int ST_SV_BIT = 11;
   localparam int ST_E_BIT = 12;
   localparam int ST_SL_BIT = 13;
   localparam int CMD_AMT_LSB = 4;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

   // ****************************************
   // Commands
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_LSHR = 4'h1,
      CMD_ASHR = 4'h2,
      CMD_CMP = 4'h3
   } msc_cmd_type;

   typedef struct packed {
      msc_cmd_type cmd;
      logic [AMT_WIDTH-1:0] amount;
      logic [ACC_WIDTH-1:0] acc;
      logic [ACC_WIDTH-1:0] operand;
      logic [15:0] status;
   } msc_alu_in_type;

   typedef struct packed {
      logic [ACC_WIDTH-1:0] acc;
      logic [15:0] status;
   } msc_alu_out_type;

endpackage : msc_pkg

`default_nettype wire

// ---- logic/msc_unit.sv ----
// Top of the accumulator shift and compare unit with its Wishbone slave.
// Assumes a classic Wishbone master that holds each request until ack.
//
// Operation
// - Right shifts behave identically with saturation enabled or disabled.
// - Right shifts work across all 40 accumulator bits, extension included.
// - Shift results written back are never clamped or saturated.
// - One-place right shift moves extension bit 0 into high word bit 15.
// - After a shift, extension flag set whenever extension byte is significant.
// - Compare subtracts accumulator from operand; carry bit 10 when operand smaller.
// - Compare keeps accumulator, updates negative and carry, leaves zero flag.
//
// The placing of the registers and register access over Wishbone were decided locally.
`default_nettype none
`timescale 1ns/1ns

module msc_unit (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Observed state
   output logic [msc_pkg::ACC_WIDTH-1:0] acc_o,
   output logic [15:0] mac_status_word_o,
   output logic saturation_enable_o
);
   import msc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [15:0] mac_control_word;
      logic [15:0] mac_status_word;
      logic [ACC_WIDTH-1:0] acc;
      logic [ACC_WIDTH-1:0] operand;
   } msc_state_type;

   msc_state_type st;
   msc_state_type next_st;
   msc_alu_in_type alu_in;
   msc_alu_out_type alu_out;
   logic wr;
   logic [31:0] merged;

   // Byte-lane merge of a register with write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Register word as software reads it; unmapped offsets read as zero
   function automatic logic [31:0] reg_word(input msc_state_type s, input logic [7:0] adr);
      logic [31:0] res;
      case (adr)
         OFF_CONTROL: res = {16'h0000, s.mac_control_word};
         OFF_STATUS: res = {16'h0000, s.mac_status_word};
         OFF_ACC_LOW: res = {16'h0000, s.acc[15:0]};
         OFF_ACC_HIGH: res = {16'h0000, s.acc[31:16]};
         OFF_ACC_EXT: res = {24'h000000, s.acc[39:32]};
         OFF_OP_LOW: res = {16'h0000, s.operand[15:0]};
         OFF_OP_HIGH: res = {16'h0000, s.operand[31:16]};
         OFF_OP_EXT: res = {24'h000000, s.operand[39:32]};
         default: res = 32'h0000_0000;
      endcase
      return res;
   endfunction : reg_word

   // ****************************************
   // Datapath
   // ****************************************
   msc_alu u_alu (
      .in_i(alu_in),
      .out_o(alu_out)
   );

   always_comb begin
      wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
      alu_in.cmd = CMD_NONE;
      alu_in.amount = wb_dat_i[CMD_AMT_LSB +: AMT_WIDTH];
      alu_in.acc = st.acc;
      alu_in.operand = st.operand;
      alu_in.status = st.mac_status_word;
      // A command acts only at the acknowledging edge, once per transfer
      if (wr && wb_adr_i == OFF_COMMAND && wb_sel_i[0]) begin
         case (wb_dat_i[3:0])
            CMD_LSHR: alu_in.cmd = CMD_LSHR;
            CMD_ASHR: alu_in.cmd = CMD_ASHR;
            CMD_CMP: alu_in.cmd = CMD_CMP;
            default: alu_in.cmd = CMD_NONE;
         endcase
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
      next_st.acc = alu_out.acc;
      next_st.mac_status_word = alu_out.status;
      // Old word and write data merged per byte lane before it lands
      merged = merge(reg_word(st, wb_adr_i), wb_dat_i, wb_sel_i);
      if (wb_cyc_i && wb_stb_i && !st.ack) begin
         next_st.rdata = reg_word(st, wb_adr_i);
      end
      if (wr) begin
         case (wb_adr_i)
            OFF_CONTROL: next_st.mac_control_word = merged[15:0];
            OFF_STATUS: next_st.mac_status_word = merged[15:0];
            OFF_ACC_LOW: next_st.acc[15:0] = merged[15:0];
            OFF_ACC_HIGH: next_st.acc[31:16] = merged[15:0];
            OFF_ACC_EXT: next_st.acc[39:32] = merged[7:0];
            OFF_OP_LOW: next_st.operand[15:0] = merged[15:0];
            OFF_OP_HIGH: next_st.operand[31:16] = merged[15:0];
            OFF_OP_EXT: next_st.operand[39:32] = merged[7:0];
            // Command and unmapped offsets leave the registers alone
            default: next_st.rdata = st.rdata;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{ack: 1'b0, rdata: 32'h0000_0000, mac_control_word: CONTROL_RESET,
                 mac_status_word: STATUS_RESET, acc: ACC_RESET, operand: ACC_RESET};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flip-flops
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;
   assign acc_o = st.acc;
   assign mac_status_word_o = st.mac_status_word;
   // Saturation is reported but deliberately not fed to the shifter
   assign saturation_enable_o = st.mac_control_word[CTL_SAT_BIT];

endmodule : msc_unit

`default_nettype wire

// ---- verification/msc_cpu_model.sv ----
// CPU core model issuing register accesses as a classic Wishbone master.
// Assumes the bench raises go_i for one cycle, only while idle.
`timescale 1ns/1ns
`default_nettype none
module msc_cpu_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench request
   input wire logic go_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic done_o,
   output logic [31:0] rdat_o,
   // Wishbone master
   input wire logic ack_i,
   input wire logic [31:0] rd_i,
   output logic cyc_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [31:0] dat_o
);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_o <= 1'b0;
         done_o <= 1'b0;
         rdat_o <= 32'h0;
         we_o <= 1'b0;
         adr_o <= 8'h00;
         dat_o <= 32'h0;
      end else if (cyc_o && ack_i) begin
         // Released data flips so a stale value never passes for a driven one
         cyc_o <= 1'b0;
         dat_o <= ~dat_o;
         // Read data is taken at the acknowledging edge only
         if (!we_o) begin
            rdat_o <= rd_i;
         end
         done_o <= 1'b1;
      end else begin
         done_o <= 1'b0;
         if (go_i) begin
            cyc_o <= 1'b1;
            we_o <= we_i;
            adr_o <= adr_i;
            dat_o <= dat_i;
         end
      end
   end
endmodule : msc_cpu_model
`default_nettype wire

// ---- verification/msc_unit_sva.sv ----
// Assertions on the ports of the shift and compare unit.
// Assumes a master that holds each request until ack.
`timescale 1ns/1ns
`default_nettype none
module msc_unit_sva import msc_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // State
   input wire logic [msc_pkg::ACC_WIDTH-1:0] acc_o,
   input wire logic [15:0] mac_status_word_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic cmd;
   logic shf;
   logic [4:0] sh;
   assign cmd = wb_ack_o && wb_we_i && wb_adr_i == OFF_COMMAND && wb_sel_i[0];
   assign shf = cmd && (wb_dat_i[3:0] == CMD_LSHR || wb_dat_i[3:0] == CMD_ASHR);
   assign sh = wb_dat_i[8:4];
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_lshr_value: assert property (
      cmd && wb_dat_i[3:0] == CMD_LSHR |=> acc_o == $past(acc_o) >> $past(sh))
      else $error("logical shift wrong");
   chk_ashr_value: assert property (
      cmd && wb_dat_i[3:0] == CMD_ASHR
      |=> $signed(acc_o) == ($signed($past(acc_o)) >>> $past(sh)))
      else $error("arithmetic shift wrong");
   chk_ext_to_high: assert property (
      shf && sh == 5'h01 |=> acc_o[31] == $past(acc_o[32]))
      else $error("extension bit lost");
   chk_shift_carry: assert property (
      shf && sh != 5'h00 |=> mac_status_word_o[ST_C_BIT] == $past(acc_o[sh - 5'h01]))
      else $error("shift carry wrong");
   chk_ext_flag: assert property (
      shf |=> mac_status_word_o[ST_E_BIT] == !(acc_o[39:31] == 9'h000 || &acc_o[39:31]))
      else $error("extension flag wrong");
   chk_cmp_keeps: assert property (
      cmd && wb_dat_i[3:0] == CMD_CMP |=> $stable(acc_o) && $stable(mac_status_word_o[ST_Z_BIT]))
      else $error("compare changed state");
   cover property (cmd && wb_dat_i[3:0] == CMD_CMP);
   cover property (shf && sh == 5'h01);
   cover property (shf ##1 mac_status_word_o[ST_E_BIT]);
endmodule : msc_unit_sva
bind msc_unit msc_unit_sva chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_ack_o, .acc_o, .mac_status_word_o);
`default_nettype wire

// ---- verification/test_mac_shift_compare_flags.sv ----
// Self-checking bench for the accumulator shift and compare unit.
// Assumes the CPU model as bus master and zero reset values.
`timescale 1ns/1ns
`default_nettype none
module test_mac_shift_compare_flags;
   import msc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i;
   logic go = 1'b0, wr = 1'b0, done, cyc, we, ack, sat, n, z, cf, e;
   logic [7:0] ad = 8'h00, adr;
   logic [31:0] wd = 32'h0, dw, dr, rdv;
   logic [39:0] acc, r;
   logic [15:0] st;
   int mismatches = 0, tests_run = 0;
   msc_unit uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .acc_o(acc),
      .mac_status_word_o(st), .saturation_enable_o(sat));
   msc_cpu_model cpu (.clk_i, .rst_i, .go_i(go), .we_i(wr), .adr_i(ad), .dat_i(wd),
      .done_o(done), .rdat_o(rdv), .ack_i(ack), .rd_i(dr), .cyc_o(cyc), .we_o(we),
      .adr_o(adr), .dat_o(dw));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string nm, input logic [39:0] x, input logic [39:0] g);
      tests_run++;
      if (g !== x) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      go <= 1'b1;
      wr <= w;
      ad <= a;
      wd <= d;
      @(posedge clk_i);
      go <= 1'b0;
      while (done !== 1'b1) begin
         @(posedge clk_i);
         k++;
         if (k > 20) begin
            mismatches++;
            report_and_stop();
         end
      end
   endtask : xfer
   function automatic logic [43:0] expect_of(input logic [3:0] c, input logic [4:0] s,
      input logic [39:0] a, input logic [39:0] o, input logic zi, input logic ei);
      logic [39:0] q;
      logic [39:0] d;
      d = o - a;
      if (c == CMD_CMP) return {a, d[39], zi, o < a, ei};
      if (c == CMD_LSHR) begin
         q = a >> s;
      end else begin
         q = $signed(a) >>> s;
      end
      return {q, q[39], q == 40'h0, s != 5'h00 && a[s - 5'h01], !(q[39:31] == 9'h000 || &q[39:31])};
   endfunction : expect_of
   // Saturation is set from ss before each shift, on in some runs and off in others; clearing it first must be unnecessary
   task automatic run(input logic [3:0] c, input logic [4:0] s, input logic [39:0] a,
      input logic [39:0] o, input logic ss);
      xfer(1'b1, OFF_CONTROL, {24'h0, ss, 7'h00});
      check("sat_enable", 40'(ss), 40'(sat));
      xfer(1'b1, OFF_ACC_LOW, {16'h0, a[15:0]});
      xfer(1'b1, OFF_ACC_HIGH, {16'h0, a[31:16]});
      xfer(1'b1, OFF_ACC_EXT, {24'h0, a[39:32]});
      xfer(1'b1, OFF_OP_LOW, {16'h0, o[15:0]});
      xfer(1'b1, OFF_OP_HIGH, {16'h0, o[31:16]});
      xfer(1'b1, OFF_OP_EXT, {24'h0, o[39:32]});
      xfer(1'b1, OFF_COMMAND, {23'h0, s, c});
      {r, n, z, cf, e} = expect_of(c, s, a, o, z, e);
      check("acc", r, acc);
      check("status", 40'({3'h0, e, 1'b0, cf, z, n, 8'h00}), 40'(st));
   endtask : run
   initial begin
      rst_i <= 1'b1;
      void'($urandom(24814));
      {n, z, cf, e} = 4'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      check("acc_reset", ACC_RESET, acc);
      check("status_reset", 40'(STATUS_RESET), 40'(st));
      run(CMD_LSHR, 5'h01, 40'h7f_5555_5555, 40'h0, 1'b1);
      run(CMD_ASHR, 5'h01, 40'h7f_5555_5555, 40'h0, 1'b1);
      run(CMD_CMP, 5'h00, 40'h00_0007_0000, 40'h00_0006_0000, 1'b1);
      run(CMD_ASHR, 5'h1f, 40'h80_0000_0001, 40'h0, 1'b0);
      run(CMD_LSHR, 5'h00, 40'hff_ffff_ffff, 40'h0, 1'b1);
      repeat (40) begin
         run(4'($urandom_range(3, 1)), 5'($urandom), {8'($urandom), 32'($urandom)},
            {8'($urandom), 32'($urandom)}, 1'($urandom));
      end
      xfer(1'b0, OFF_STATUS, 32'h0);
      check("status_read", 40'({3'h0, e, 1'b0, cf, z, n, 8'h00}), 40'(rdv));
      xfer(1'b0, 8'h3c, 32'h0);
      check("unmapped_read", 40'h0, 40'(rdv));
      report_and_stop();
   end
endmodule : test_mac_shift_compare_flags
`default_nettype wire
